// *** etp_defs.svh ***
/*
  Register offsets, field positions, reset values and counts of the
  enhanced timer PWM, single pulse and capture block.
  Assumes inclusion by bare name from the block's design file.
*/
`ifndef ETP_DEFS_SVH
`define ETP_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ETP_OFF_CTRL  12'h000
`define ETP_OFF_PRD   12'h004
`define ETP_OFF_CCA   12'h008
`define ETP_OFF_CCB   12'h00c
`define ETP_OFF_FLAG  12'h010
`define ETP_OFF_CNT   12'h014

// ----------------------------------------
// Control field positions (low bit)
// ----------------------------------------
`define ETP_CTRL_RUN  0
`define ETP_CTRL_AM   1
`define ETP_CTRL_BM   3
`define ETP_CTRL_AIO  5
`define ETP_CTRL_BIO  7
`define ETP_CTRL_PWM  9
`define ETP_CTRL_CCLR 11
`define ETP_CTRL_AOC  12
`define ETP_CTRL_BOC  13
`define ETP_CTRL_APOL 14
`define ETP_CTRL_BPOL 15
`define ETP_CTRL_W    16

// ----------------------------------------
// Flag positions, widths, reset values
// ----------------------------------------
`define ETP_FLAG_P    0
`define ETP_FLAG_A    1
`define ETP_FLAG_B    2
`define ETP_FLAG_W    3
`define ETP_PRD_W     3
`define ETP_CNT_W     10
`define ETP_CTRL_RST  16'h0000
`define ETP_PRD_RST   3'h0
`define ETP_CC_RST    10'h000
`define ETP_FLAG_RST  3'h0

`endif

// *** etp_pkg.sv ***
/*
  Types of the enhanced timer block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package etp_pkg;

  // ----------------------------------------
  // Operating mode, one-hot
  // ----------------------------------------
  typedef enum logic [3:0] {
    MODE_IDLE  = 4'b0001,
    MODE_PWM   = 4'b0010,
    MODE_PULSE = 4'b0100,
    MODE_CAPT  = 4'b1000
  } etp_mode_t;

endpackage : etp_pkg

// *** etp_timer.sv ***
/*
  Enhanced timer: PWM (edge and centre aligned), single pulse and
  input capture, with registers on APB.
  Assumes a single 100 MHz clock, pins from outside the clock domain,
  and software setting both channel mode fields alike.
*/
`include "etp_defs.svh"

module etp_timer (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // APB slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Timer pins
  input  wire logic        timerPinAIn,
  output logic             timerPinAOut,
  output logic             timerPinAOe,
  input  wire logic        timerPinBIn,
  output logic             timerPinBOut,
  output logic             timerPinBOe,
  input  wire logic        externalTriggerPin
);
  import etp_pkg::*;

  localparam int CW = `ETP_CNT_W;
  localparam int SH = CW - `ETP_PRD_W;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [`ETP_CTRL_W-1:0] ctrl;
  logic [`ETP_PRD_W-1:0]  periodCompareValue;
  logic [CW-1:0]          compareAValue, compareBValue;
  logic [`ETP_FLAG_W-1:0] flag;
  logic [CW-1:0]          cnt;
  logic                   down, runPrev, pulseA, pulseB;
  logic [2:0]             sync1, sync2, sync3, filt, filtPrev;

  // ----------------------------------------
  // Control decode
  // ----------------------------------------
  logic        timerRunBit, counterClearSelect, centre, runRise;
  logic        outputAInitialLevel, outputBInitialLevel, outputAPolarity, outputBPolarity;
  logic [1:0]  channelAModeSelect, outputAActionSelect;
  logic [1:0]  outputBActionSelect, pwmAlignmentSelect;
  etp_mode_t   curMode;
  logic        isPwm, isPulse, isCapt;

  assign timerRunBit         = ctrl[`ETP_CTRL_RUN];
  assign channelAModeSelect  = ctrl[`ETP_CTRL_AM +: 2];
  assign outputAActionSelect = ctrl[`ETP_CTRL_AIO +: 2];
  assign outputBActionSelect = ctrl[`ETP_CTRL_BIO +: 2];
  assign pwmAlignmentSelect  = ctrl[`ETP_CTRL_PWM +: 2];
  assign counterClearSelect  = ctrl[`ETP_CTRL_CCLR];
  assign outputAInitialLevel = ctrl[`ETP_CTRL_AOC];
  assign outputBInitialLevel = ctrl[`ETP_CTRL_BOC];
  assign outputAPolarity     = ctrl[`ETP_CTRL_APOL];
  assign outputBPolarity     = ctrl[`ETP_CTRL_BPOL];

  // Mode 10 with action 11 is single pulse, otherwise PWM
  assign curMode = (channelAModeSelect == 2'h2) ?
                   ((outputAActionSelect == 2'h3) ? MODE_PULSE : MODE_PWM) :
                   (channelAModeSelect == 2'h1) ? MODE_CAPT : MODE_IDLE;
  assign isPwm   = (curMode == MODE_PWM);
  assign isPulse = (curMode == MODE_PULSE);
  assign isCapt  = (curMode == MODE_CAPT);
  assign centre  = (pwmAlignmentSelect == 2'h3);
  assign runRise = timerRunBit & ~runPrev;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] syncDiff, next_filt, rise, fall;
  assign syncDiff  = sync2 ^ sync3;
  assign next_filt = (sync3 & ~syncDiff) | (filt & syncDiff);
  assign rise      = filt & ~filtPrev;
  assign fall      = ~filt & filtPrev;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1    <= 3'h0;
      sync2    <= 3'h0;
      sync3    <= 3'h0;
      filt     <= 3'h0;
      filtPrev <= 3'h0;
    end else begin
      sync1    <= {externalTriggerPin, timerPinBIn, timerPinAIn};
      sync2    <= sync1;
      sync3    <= sync2;
      filt     <= next_filt;
      filtPrev <= filt;
    end
  end

  // ----------------------------------------
  // Period limits
  // ----------------------------------------
  logic [CW:0] prdBase, prdEdge, prdHalf, cntWide;
  logic        edgeWrap, capWrap;
  assign cntWide = {1'b0, cnt};
  assign prdBase = {1'b0, periodCompareValue, {SH{1'b0}}};
  assign prdEdge = counterClearSelect ? {1'b0, compareAValue} :
                   (periodCompareValue == `ETP_PRD_RST) ?
                   {1'b1, {CW{1'b0}}} : prdBase;
  // half period 128 per code, 0 gives 1023
  // clear high, half period is compare A
  assign prdHalf = counterClearSelect ? {1'b0, compareAValue} :
                   (periodCompareValue == `ETP_PRD_RST) ?
                   {1'b0, {CW{1'b1}}} : prdBase;
  assign edgeWrap = (cntWide == prdEdge - {{CW{1'b0}}, 1'b1});
  // period match bounds the capture count
  // period zero never matches, counter wraps at max
  assign capWrap = (periodCompareValue != `ETP_PRD_RST) &&
                   (cntWide == prdBase);

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  logic [CW-1:0] next_cnt;
  logic          next_down, hitP, hitA, hitB;
  always_comb begin
    next_cnt  = cnt;
    next_down = down;
    hitP      = 1'b0;
    hitA      = 1'b0;
    hitB      = 1'b0;
    // counter zeroed at run rise and at the edge PWM and capture period wraps
    if (runRise) begin
      next_cnt  = '0;
      next_down = 1'b0;
    end else if (timerRunBit) begin
      unique case (curMode)
        MODE_PWM: begin
          hitB = (cnt == compareBValue);
          if (!centre) begin
            next_cnt = edgeWrap ? '0 : cnt + 1'b1;
            hitP     = edgeWrap & ~counterClearSelect;
            hitA     = counterClearSelect ? edgeWrap : (cnt == compareAValue);
          end else begin
            hitA = (cnt == compareAValue);
            if (!down) begin
              if (cntWide == prdHalf) begin
                next_cnt  = cnt - 1'b1;
                next_down = 1'b1;
              end else begin
                next_cnt = cnt + 1'b1;
              end
            end else begin
              next_cnt = cnt - 1'b1;
              if (cnt == {{(CW-1){1'b0}}, 1'b1}) begin
                next_down = 1'b0;
                hitP      = 1'b1;
              end
            end
          end
        end
        MODE_PULSE: begin
          next_cnt = cnt + 1'b1;
          hitA     = (cnt == compareAValue);
          hitB     = (cnt == compareBValue);
        end
        // count while run bit high, zeroed at period match
        MODE_CAPT: begin
          next_cnt = capWrap ? '0 : cnt + 1'b1;
          hitP     = capWrap;
        end
        MODE_IDLE: begin
          next_cnt = cnt + 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt     <= `ETP_CC_RST;
      down    <= 1'b0;
      runPrev <= 1'b0;
    end else begin
      cnt     <= next_cnt;
      down    <= next_down;
      runPrev <= timerRunBit;
    end
  end

  // ----------------------------------------
  // Single pulse outputs
  // ----------------------------------------
  logic next_pulseA, next_pulseB, pulseEnd;
  // compare A or run low closes both
  assign pulseEnd    = isPulse & hitA;
  assign next_pulseA = isPulse & timerRunBit & (runRise | pulseA) & ~hitA;
  assign next_pulseB = isPulse & timerRunBit & ~runRise &
                       (pulseB | hitB) & ~hitA;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pulseA <= 1'b0;
      pulseB <= 1'b0;
    end else begin
      pulseA <= next_pulseA;
      pulseB <= next_pulseB;
    end
  end

  // ----------------------------------------
  // Capture
  // ----------------------------------------
  logic capA, capB;
  assign capA = isCapt & ((outputAActionSelect == 2'h0) ? rise[0] :
                          (outputAActionSelect == 2'h1) ? fall[0] :
                          (outputAActionSelect == 2'h2) ? (rise[0] | fall[0]) :
                          1'b0);
  assign capB = isCapt & ((outputBActionSelect == 2'h0) ? rise[1] :
                          (outputBActionSelect == 2'h1) ? fall[1] :
                          (outputBActionSelect == 2'h2) ? (rise[1] | fall[1]) :
                          1'b0);

  // ----------------------------------------
  // PWM waveform and pins
  // ----------------------------------------
  logic pwmA, pwmB, actA, actB;
  // compare below both slopes gives 2C-1
  // compare at or above period stays active
  assign pwmA = timerRunBit & (cnt < compareAValue);
  assign pwmB = timerRunBit & (cnt < compareBValue);
  assign actA = isPwm ? ((outputAActionSelect == 2'h0) ? 1'b0 :
                         (outputAActionSelect == 2'h1) ? 1'b1 : pwmA) : pulseA;
  assign actB = isPwm ? ((outputBActionSelect == 2'h0) ? 1'b0 :
                         (outputBActionSelect == 2'h1) ? 1'b1 : pwmB) : pulseB;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      timerPinAOut <= 1'b0;
      timerPinBOut <= 1'b0;
      timerPinAOe  <= 1'b0;
      timerPinBOe  <= 1'b0;
    end else begin
      timerPinAOut <= (actA ~^ outputAInitialLevel) ^ outputAPolarity;
      timerPinBOut <= (actB ~^ outputBInitialLevel) ^ outputBPolarity;
      timerPinAOe  <= isPwm | isPulse;
      timerPinBOe  <= isPwm | isPulse;
    end
  end

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  logic        setup, wrEn, hitAddr;
  logic        wrCtrl, wrPrd, wrCca, wrCcb, wrFlag;
  logic [31:0] rdMux;
  assign setup   = psel & ~penable;
  assign wrEn    = psel & penable & pready & pwrite & ~pslverr;
  assign hitAddr = (paddr == `ETP_OFF_CTRL) || (paddr == `ETP_OFF_PRD) ||
                   (paddr == `ETP_OFF_CCA) || (paddr == `ETP_OFF_CCB) ||
                   (paddr == `ETP_OFF_FLAG) || (paddr == `ETP_OFF_CNT);
  assign wrCtrl  = wrEn & (paddr == `ETP_OFF_CTRL);
  assign wrPrd   = wrEn & (paddr == `ETP_OFF_PRD);
  assign wrCca   = wrEn & (paddr == `ETP_OFF_CCA);
  assign wrCcb   = wrEn & (paddr == `ETP_OFF_CCB);
  assign wrFlag  = wrEn & (paddr == `ETP_OFF_FLAG);
  assign rdMux   = (paddr == `ETP_OFF_CTRL) ? {16'h0000, ctrl} :
                   (paddr == `ETP_OFF_PRD)  ? {29'h0, periodCompareValue} :
                   (paddr == `ETP_OFF_CCA)  ? {22'h0, compareAValue} :
                   (paddr == `ETP_OFF_CCB)  ? {22'h0, compareBValue} :
                   (paddr == `ETP_OFF_FLAG) ? {29'h0, flag} :
                   (paddr == `ETP_OFF_CNT)  ? {22'h0, cnt} : 32'h0;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hitAddr;
      prdata  <= setup ? rdMux : prdata;
    end
  end

  // ----------------------------------------
  // Register update
  // ----------------------------------------
  logic [`ETP_CTRL_W-1:0] ctrlSw;
  logic                   trigRise, next_run;
  logic [`ETP_FLAG_W-1:0] flagClr, flagSet;
  assign ctrlSw   = wrCtrl ? pwdata[`ETP_CTRL_W-1:0] : ctrl;
  // trigger edge sets run, wins over clears
  assign trigRise = isPulse & rise[2];
  assign next_run = trigRise | (~pulseEnd & ctrlSw[`ETP_CTRL_RUN]);
  assign flagClr  = wrFlag ? pwdata[`ETP_FLAG_W-1:0] : `ETP_FLAG_RST;
  assign flagSet  = {hitB | capB, hitA | capA, hitP};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl               <= `ETP_CTRL_RST;
      periodCompareValue <= `ETP_PRD_RST;
      compareAValue      <= `ETP_CC_RST;
      compareBValue      <= `ETP_CC_RST;
      flag               <= `ETP_FLAG_RST;
    end else begin
      ctrl <= {ctrlSw[`ETP_CTRL_W-1:1], next_run};
      periodCompareValue <= wrPrd ? pwdata[`ETP_PRD_W-1:0] : periodCompareValue;
      // capture latches counter, wins over write
      compareAValue <= capA ? cnt : wrCca ? pwdata[CW-1:0] : compareAValue;
      compareBValue <= capB ? cnt : wrCcb ? pwdata[CW-1:0] : compareBValue;
      flag <= (flag & ~flagClr) | flagSet;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  chk_centre_zero_flag: assert property (
    (isPwm && centre && timerRunBit && !runRise && down && cnt == 10'h001)
    |=> flag[`ETP_FLAG_P] && cnt == 10'h000)
    else $error("centre period flag missing at zero");
  chk_pulse_a_start: assert property (
    (isPulse && runRise) |=> pulseA && cnt == 10'h000)
    else $error("pulse A not started by run rise");
  chk_pulse_b_start: assert property (
    (isPulse && timerRunBit && !runRise && cnt == compareBValue &&
     cnt != compareAValue) |=> pulseB && flag[`ETP_FLAG_B])
    else $error("pulse B not started on compare B");
  chk_trigger_run: assert property (
    trigRise |=> timerRunBit)
    else $error("trigger did not set run");
  chk_pulse_end: assert property (
    (pulseEnd && !trigRise) |=> !timerRunBit && !pulseA && !pulseB ##1 !pulseA)
    else $error("compare A did not end pulse");
  chk_capture_latch: assert property (
    capA |=> compareAValue == $past(cnt) && flag[`ETP_FLAG_A])
    else $error("capture A value or flag wrong");
  chk_capture_wrap: assert property (
    (isCapt && timerRunBit && !runRise && capWrap)
    |=> cnt == 10'h000 && flag[`ETP_FLAG_P])
    else $error("period match did not zero counter");
  chk_capture_none: assert property (
    (isCapt && outputAActionSelect == 2'h3 && !wrCca)
    |=> compareAValue == $past(compareAValue))
    else $error("capture taken while disabled");
  chk_pulse_count: assert property (
    (isPulse && timerRunBit && !runRise) |=> cnt == $past(cnt) + 10'h001)
    else $error("pulse counter not counting up");
  chk_flag_hold: assert property (
    (flag[`ETP_FLAG_A] && !(wrFlag && pwdata[`ETP_FLAG_A])) |=> flag[`ETP_FLAG_A])
    else $error("flag A dropped without clear");
  chk_full_duty: assert property (
    (isPwm && !centre && timerRunBit && !runRise && {1'b0, compareBValue} >= prdEdge) |-> pwmB)
    else $error("duty at period not full");

endmodule : etp_timer

// *** etp_pin_model.sv ***
/*
  Pin model: signal sources and loads on timer pins A, B and trigger.
  Assumes the timer's pin outputs, enables and its clock.
*/
module etp_pin_model (
  // Clock
  input  wire logic clk,
  // Timer pin side
  input  wire logic pinAOut,
  input  wire logic pinAOe,
  input  wire logic pinBOut,
  input  wire logic pinBOe,
  // Resolved levels
  output logic      pinA,
  output logic      pinB,
  output logic      trig
);
  timeunit 1ns;
  timeprecision 1ns;
  logic srcA = 1'b0;
  logic srcB = 1'b0;
  initial trig = 1'b0;
  // Timer drive wins over the external source
  assign pinA = pinAOe ? pinAOut : srcA;
  assign pinB = pinBOe ? pinBOut : srcB;
  task automatic drive(input logic a, input logic b);
    @(posedge clk);
    srcA <= a;
    srcB <= b;
  endtask : drive
  task automatic trigger(input logic lvl);
    @(posedge clk);
    trig <= lvl;
  endtask : trigger
  // Load side: count high cycles on both pins
  task automatic measure(input int n, output int ha, output int hb);
    ha = 0;
    hb = 0;
    repeat (n) begin
      @(posedge clk);
      ha += int'(pinA);
      hb += int'(pinB);
    end
  endtask : measure
endmodule : etp_pin_model

// *** etp_timer_tb.sv ***
/*
  Self-checking bench of the enhanced timer: APB master, pin model.
  Assumes etp_defs.svh and the timer with its pin model.
*/
`include "etp_defs.svh"
module etp_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, resetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        aOut, aOe, bOut, bOe, pinA, pinB, trig;
  int          fails, nCompared, ha, hb, cca, ccb;

  etp_timer etp_timer_inst (.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timerPinAIn(pinA), .timerPinAOut(aOut),
    .timerPinAOe(aOe), .timerPinBIn(pinB), .timerPinBOut(bOut), .timerPinBOe(bOe),
    .externalTriggerPin(trig));
  etp_pin_model etp_pin_model_inst (.clk(clk), .pinAOut(aOut), .pinAOe(aOe),
    .pinBOut(bOut), .pinBOe(bOe), .pinA(pinA), .pinB(pinB), .trig(trig));

  // ----------------------------------------
  // Bus, compare and report tasks
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_count(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_count
  task automatic final_report();
    $display("compared %0d mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------
  // Reference model
  // ----------------------------------------
  function automatic int prd_len(input int code, input bit ctr);
    if (ctr) return (code == 0) ? 2046 : code * 256;
    return (code == 0) ? 1024 : code * 128;
  endfunction : prd_len
  function automatic int duty(input int c, input int per, input bit ctr);
    int d = ctr ? 2 * c - 1 : c;
    return (d >= per) ? per : d;
  endfunction : duty
  function automatic logic [31:0] cw(int run, int m, int ia, int ib, int al, int cl);
    return 32'(run + m * 10 + ia * 32 + ib * 128 + al * 512 + cl * 2048 + 12288);
  endfunction : cw
  task automatic pwm_run(int code, int ca, int cb, int ia, int al, int cl, int per,
                         int ea, int eb);
    apb(1'b1, `ETP_OFF_PRD, 32'(code));
    apb(1'b1, `ETP_OFF_CCA, 32'(ca));
    apb(1'b1, `ETP_OFF_CCB, 32'(cb));
    apb(1'b1, `ETP_OFF_FLAG, 32'h7);
    apb(1'b1, `ETP_OFF_CTRL, cw(1, 2, ia, 2, al, cl));
    repeat (2 * per + 8) @(posedge clk);
    etp_pin_model_inst.measure(2 * per, ha, hb);
    chk_count(ha, 2 * ea);
    chk_count(hb, 2 * eb);
    apb(1'b0, `ETP_OFF_FLAG, 32'h0);
    chk_reg(rd & 32'h1, 32'h1);
    apb(1'b1, `ETP_OFF_CTRL, 32'h0);
  endtask : pwm_run

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #500000;
    fails++;
    final_report();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
    fails = 0;
    nCompared = 0;
    void'($urandom(32'h09b6));
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk_reg(rd, 32'h0);
    end
    apb(1'b1, 12'h018, 32'hffffffff);
    apb(1'b0, 12'h018, 32'h0);
    chk_reg({rd[30:0], err}, 32'h1);
    cca = 40;
    ccb = 5 + int'($urandom % 20);
    apb(1'b1, `ETP_OFF_CCA, 32'(cca));
    apb(1'b1, `ETP_OFF_CCB, 32'(ccb));
    apb(1'b1, `ETP_OFF_CTRL, cw(1, 2, 3, 3, 0, 0));
    etp_pin_model_inst.measure(cca + 30, ha, hb);
    chk_count(ha, cca + 1);
    chk_count(hb, cca - ccb);
    apb(1'b0, `ETP_OFF_CTRL, 32'h0);
    chk_reg(rd & 32'h1, 32'h0);
    apb(1'b0, `ETP_OFF_FLAG, 32'h0);
    chk_reg(rd & 32'h6, 32'h6);
    apb(1'b1, `ETP_OFF_FLAG, 32'h7);
    apb(1'b0, `ETP_OFF_FLAG, 32'h0);
    chk_reg(rd, 32'h0);
    apb(1'b1, `ETP_OFF_CTRL, cw(0, 2, 3, 3, 0, 1));
    etp_pin_model_inst.trigger(1'b1);
    etp_pin_model_inst.measure(cca + 30, ha, hb);
    etp_pin_model_inst.trigger(1'b0);
    chk_count(ha, cca + 1);
    chk_count(hb, cca - ccb);
    apb(1'b1, `ETP_OFF_CCA, 32'd200);
    apb(1'b1, `ETP_OFF_CTRL, cw(1, 2, 3, 3, 0, 0));
    apb(1'b1, `ETP_OFF_CTRL, cw(0, 2, 3, 3, 0, 0));
    repeat (4) @(posedge clk);
    etp_pin_model_inst.measure(30, ha, hb);
    chk_count(ha + hb, 0);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, `ETP_OFF_PRD, 32'h0);
      apb(1'b1, `ETP_OFF_CCA, 32'h0);
      apb(1'b1, `ETP_OFF_CCB, 32'h0);
      apb(1'b1, `ETP_OFF_FLAG, 32'h7);
      apb(1'b1, `ETP_OFF_CTRL, cw(1, 1, k, k, 0, 1));
      repeat (10) @(posedge clk);
      etp_pin_model_inst.drive(1'b1, 1'b1);
      repeat (20) @(posedge clk);
      etp_pin_model_inst.drive(1'b0, 1'b0);
      repeat (20) @(posedge clk);
      apb(1'b0, `ETP_OFF_FLAG, 32'h0);
      chk_reg(rd & 32'h6, (k == 3) ? 32'h0 : 32'h6);
      apb(1'b0, `ETP_OFF_CCA, 32'h0);
      cca = int'(rd);
      apb(1'b0, `ETP_OFF_CNT, 32'h0);
      chk_count(int'(int'(rd) > cca && ((cca != 0) == (k != 3))), 1);
      apb(1'b1, `ETP_OFF_CTRL, 32'h0);
    end
    apb(1'b1, `ETP_OFF_PRD, 32'h1);
    apb(1'b1, `ETP_OFF_FLAG, 32'h7);
    apb(1'b1, `ETP_OFF_CTRL, cw(1, 1, 3, 3, 0, 0));
    repeat (300) @(posedge clk);
    apb(1'b0, `ETP_OFF_FLAG, 32'h0);
    chk_reg(rd & 32'h7, 32'h1);
    apb(1'b0, `ETP_OFF_CNT, 32'h0);
    chk_count(int'(rd <= 32'd128), 1);
    apb(1'b1, `ETP_OFF_CTRL, 32'h0);
    ccb = 1 + int'($urandom % 127);
    pwm_run(1, 32, 200, 2, 0, 0, 128, duty(32, 128, 0), duty(200, 128, 0));
    pwm_run(1, 32, ccb, 1, 0, 0, 128, 128, duty(ccb, 128, 0));
    pwm_run(1, 32, ccb, 2, 3, 0, prd_len(1, 1), duty(32, 256, 1),
            duty(ccb, 256, 1));
    pwm_run(0, 1000, 1023, 2, 3, 0, prd_len(0, 1), duty(1000, 2046, 1),
            duty(1023, 2046, 1));
    pwm_run(0, 50, 10, 0, 3, 1, 100, 0, duty(10, 100, 1));
    final_report();
  end
endmodule : etp_timer_tb
